// ---- design/clk_gate_pkg.sv ----
// Package for the sleep clock gating controller: offsets, field layout, reset values, modes.
// Assumes a 32-bit register port with word offsets and a single system clock.
package clk_gate_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int UNIT_N = 8;
	// Register offsets
	localparam logic [ADDR_W-1:0] RUN_GATE_OFS = 12'h104;
	localparam logic [ADDR_W-1:0] SLEEP_GATE_OFS = 12'h114;
	localparam logic [ADDR_W-1:0] DEEP_GATE_OFS = 12'h124;
	localparam logic [ADDR_W-1:0] RUN_CFG_OFS = 12'h060;
	localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 12'h200;
	localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 12'h204;
	localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 12'h208;
	localparam logic [ADDR_W-1:0] POWER_MODE_OFS = 12'h20C;
	// Gate register layout
	localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] GATE_WRITABLE = 32'h0107_1013;
	localparam int ASYNC_ZERO_BIT = 0;
	localparam int ASYNC_ONE_BIT = 1;
	localparam int SYNC_ZERO_BIT = 4;
	localparam int TWO_WIRE_BIT = 12;
	localparam int COUNTER_ZERO_BIT = 16;
	localparam int COUNTER_ONE_BIT = 17;
	localparam int COUNTER_TWO_BIT = 18;
	localparam int COMPARATOR_BIT = 24;
	// Unit index to gate bit position
	localparam int UNIT_BIT [UNIT_N] = '{ASYNC_ZERO_BIT, ASYNC_ONE_BIT, SYNC_ZERO_BIT,
		TWO_WIRE_BIT, COUNTER_ZERO_BIT, COUNTER_ONE_BIT, COUNTER_TWO_BIT, COMPARATOR_BIT};
	// Run clock configuration layout
	localparam int AUTO_GATE_BIT = 27;
	localparam logic [DATA_W-1:0] RUN_CFG_RESET = 32'h0000_0000;
	// Interrupt status layout
	localparam int IRQ_FAULT_BIT = 0;
	localparam int IRQ_W = 1;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 1'h0;
	// Power modes
	typedef enum logic [1:0] {
		MODE_RUN = 2'h0,
		MODE_SLEEP = 2'h1,
		MODE_DEEP = 2'h2
	} power_mode_t;
	localparam logic [1:0] MODE_RESET = 2'h0;
endpackage : clk_gate_pkg

// ---- design/gate_select.sv ----
// Chooses the active per-unit enable set from run, sleep and deep-sleep gate registers.
// Assumes the power mode and the auto gating select are stable register outputs.
module gate_select
	import clk_gate_pkg::*;
(
	input wire logic [DATA_W-1:0] runGate,
	input wire logic [DATA_W-1:0] sleepGate,
	input wire logic [DATA_W-1:0] deepGate,
	input wire logic autoGate,
	input wire logic [1:0] powerMode,
	output logic [UNIT_N-1:0] unitEnable
);
	wire logic [DATA_W-1:0] activeGate;
	wire logic sleeping;
	wire logic deep;

	// Sleep sets apply only with auto gating; otherwise run enables stay in force
	assign sleeping = autoGate && (powerMode == MODE_SLEEP);
	assign deep = autoGate && (powerMode == MODE_DEEP);
	assign activeGate = sleeping ? sleepGate : (deep ? deepGate : runGate);

	// One enable per covered unit, picked from its documented bit
	genvar u;
	generate
		for (u = 0; u < UNIT_N; u++) begin : g_unit
			assign unitEnable[u] = activeGate[UNIT_BIT[u]];
		end
	endgenerate
endmodule : gate_select

// ---- design/fault_detect.sv ----
// Flags a peripheral access aimed at a unit whose clock is currently off.
// Assumes the system bus presents a one-hot unit select with a valid strobe.
module fault_detect
	import clk_gate_pkg::*;
(
	input wire logic [UNIT_N-1:0] unitEnable,
	input wire logic [UNIT_N-1:0] periphSel,
	input wire logic periphValid,
	output logic faultNow
);
	wire logic [UNIT_N-1:0] gatedHit;

	// Any selected unit without a clock turns the access into a fault
	assign gatedHit = periphSel & ~unitEnable;
	assign faultNow = periphValid && (|gatedHit);
endmodule : fault_detect

// ---- design/sleep_clock_gating_ctrl.sv ----
// Sleep clock gating controller: gate registers, mode selection, bus fault and interrupt.
// Assumes a one-cycle register port and that the clock gating cells sit downstream.
//
// Chosen here: the strobed register port.
module sleep_clock_gating_ctrl
	import clk_gate_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic [DATA_W-1:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [DATA_W-1:0] regRdata,
	input wire logic [UNIT_N-1:0] periphSel,
	input wire logic periphValid,
	output logic busFault,
	output logic async_serial_zero_gate,
	output logic async_serial_one_gate,
	output logic sync_serial_zero_gate,
	output logic two_wire_zero_gate,
	output logic general_counter_zero_gate,
	output logic general_counter_one_gate,
	output logic general_counter_two_gate,
	output logic comparator_zero_gate,
	output logic irq
);
	logic [DATA_W-1:0] run_clock_gate_one;
	logic [DATA_W-1:0] sleep_clock_gate_one;
	logic [DATA_W-1:0] deep_sleep_clock_gate_one;
	logic [DATA_W-1:0] run_clock_config;
	power_mode_t powerMode;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqEnable;
	wire logic [UNIT_N-1:0] unitEnable;
	wire logic faultNow;
	wire logic auto_gating_select;
	wire logic hitRun, hitSleep, hitDeep, hitCfg;
	wire logic hitStatus, hitEnable, hitClear, hitMode;
	wire logic [DATA_W-1:0] next_rdata;
	wire logic [DATA_W-1:0] gateWrite;
	wire logic [IRQ_W-1:0] faultEvent;
	wire logic [IRQ_W-1:0] next_irqStatus;

	// Address decode
	assign hitRun = (regAddr == RUN_GATE_OFS);
	assign hitSleep = (regAddr == SLEEP_GATE_OFS);
	assign hitDeep = (regAddr == DEEP_GATE_OFS);
	assign hitCfg = (regAddr == RUN_CFG_OFS);
	assign hitStatus = (regAddr == IRQ_STATUS_OFS);
	assign hitEnable = (regAddr == IRQ_ENABLE_OFS);
	assign hitClear = (regAddr == IRQ_CLEAR_OFS);
	assign hitMode = (regAddr == POWER_MODE_OFS);

	// Only the documented enable bits store; reserved bits stay zero
	assign gateWrite = regWdata & GATE_WRITABLE;
	assign auto_gating_select = run_clock_config[AUTO_GATE_BIT];

	// Read mux; unmapped addresses and the clear register read as zero
	assign next_rdata = hitRun ? run_clock_gate_one :
		hitSleep ? sleep_clock_gate_one :
		hitDeep ? deep_sleep_clock_gate_one :
		hitCfg ? run_clock_config :
		hitStatus ? {{(DATA_W-IRQ_W){1'b0}}, irqStatus} :
		hitEnable ? {{(DATA_W-IRQ_W){1'b0}}, irqEnable} :
		hitMode ? {{(DATA_W-2){1'b0}}, powerMode} :
		GATE_RESET;

	// Fault event sets the sticky bit; a clear in the same cycle loses to it
	assign faultEvent = faultNow ? {IRQ_W{1'b1}} : IRQ_RESET;
	assign next_irqStatus = faultEvent |
		(irqStatus & ~((regWrite && hitClear) ? regWdata[IRQ_W-1:0] : IRQ_RESET));

	gate_select u_select (
		.runGate(run_clock_gate_one),
		.sleepGate(sleep_clock_gate_one),
		.deepGate(deep_sleep_clock_gate_one),
		.autoGate(auto_gating_select),
		.powerMode(powerMode),
		.unitEnable(unitEnable)
	);

	fault_detect u_fault (
		.unitEnable(unitEnable),
		.periphSel(periphSel),
		.periphValid(periphValid),
		.faultNow(faultNow)
	);

	// Gate registers; all clear at reset so every unit starts unclocked
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_clock_gate_one <= GATE_RESET;
			sleep_clock_gate_one <= GATE_RESET;
			deep_sleep_clock_gate_one <= GATE_RESET;
		end else if (regWrite) begin
			if (hitRun) run_clock_gate_one <= gateWrite;
			if (hitSleep) sleep_clock_gate_one <= gateWrite;
			if (hitDeep) deep_sleep_clock_gate_one <= gateWrite;
		end
	end

	// Configuration: only the auto gating select bit is kept
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			run_clock_config <= RUN_CFG_RESET;
			powerMode <= MODE_RUN;
		end else if (regWrite) begin
			if (hitCfg) run_clock_config <= regWdata & (32'h0000_0001 << AUTO_GATE_BIT);
			if (hitMode) powerMode <= power_mode_t'(regWdata[1:0]);
		end
	end

	// Interrupt registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irqStatus <= IRQ_RESET;
			irqEnable <= IRQ_RESET;
			irq <= 1'b0;
		end else begin
			irqStatus <= next_irqStatus;
			if (regWrite && hitEnable) irqEnable <= regWdata[IRQ_W-1:0];
			irq <= |(next_irqStatus & ((regWrite && hitEnable) ? regWdata[IRQ_W-1:0] : irqEnable));
		end
	end

	// Read data and bus fault, registered so outputs come from flops
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			regRdata <= GATE_RESET;
			busFault <= 1'b0;
		end else begin
			regRdata <= regRead ? next_rdata : GATE_RESET;
			busFault <= faultNow;
		end
	end

	// Per-unit clock enables out to the gating cells
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			{comparator_zero_gate, general_counter_two_gate, general_counter_one_gate,
				general_counter_zero_gate, two_wire_zero_gate, sync_serial_zero_gate,
				async_serial_one_gate, async_serial_zero_gate} <= 8'h00;
		end else begin
			{comparator_zero_gate, general_counter_two_gate, general_counter_one_gate,
				general_counter_zero_gate, two_wire_zero_gate, sync_serial_zero_gate,
				async_serial_one_gate, async_serial_zero_gate} <= unitEnable;
		end
	end
endmodule : sleep_clock_gating_ctrl

// ---- test/sleep_gate_chk.sv ----
// Checker for the sleep gating controller's register, fault and gate ports.
// Assumes binding to the top module; sees its ports only.
module sleep_gate_chk
	import clk_gate_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] regAddr,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [DATA_W-1:0] regRdata,
	input wire logic [UNIT_N-1:0] periphSel,
	input wire logic periphValid,
	input wire logic busFault,
	input wire logic async_serial_zero_gate,
	input wire logic irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Faults answer accesses to unit zero by its gate
	a_fault_cause: assert property (busFault |-> $past(periphValid)) else $error("stray fault");
	a_fault_off: assert property (periphValid && periphSel == 8'h01 && !async_serial_zero_gate
		|=> busFault) else $error("no fault");
	a_fault_on: assert property (periphValid && periphSel == 8'h01 && async_serial_zero_gate
		|=> !busFault) else $error("false fault");
	// Read data only the cycle after a read; reserved sleep gate bits zero
	a_read_quiet: assert property (regRdata != '0 |-> $past(regRead)) else $error("rdata");
	a_resv_zero: assert property ($past(regRead) && $past(regAddr) == SLEEP_GATE_OFS
		|-> (regRdata & ~GATE_WRITABLE) == '0) else $error("reserved set");
	a_reset_off: assert property ($rose(rst_n) |-> !async_serial_zero_gate && !irq)
		else $error("reset state");
	// Unit zero's gate moves only after a register write
	a_gate_write: assert property ($changed(async_serial_zero_gate)
		|-> $past(regWrite) || $past(regWrite, 2)) else $error("gate moved");
	a_irq_cause: assert property ($rose(irq) |-> busFault || $past(regWrite))
		else $error("irq cause");
endmodule : sleep_gate_chk
bind sleep_clock_gating_ctrl sleep_gate_chk chk_u (.*);

// ---- test/periph_model.sv ----
// Peripheral access model: a one-hot access toward one unit.
// Assumes the bench raises go for exactly the access cycle.
module periph_model
	import clk_gate_pkg::*;
(
	input wire logic [2:0] unit,
	input wire logic go,
	output logic [UNIT_N-1:0] periphSel,
	output logic periphValid
);
	// Idle select shows the inverse, so a stale unit never looks chosen
	assign periphSel = go ? UNIT_N'(1) << unit : ~(UNIT_N'(1) << unit);
	assign periphValid = go;
endmodule : periph_model

// ---- test/tb.sv ----
// Bench for the sleep gating controller: register tasks, gate and fault checks.
// Assumes a 100 MHz clock and the access model beside the block.
module tb
	import clk_gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, regWrite = 0, regRead = 0, go = 0, periphValid, busFault, irq;
	logic [ADDR_W-1:0] regAddr = '0;
	logic [DATA_W-1:0] regWdata = '0, regRdata;
	logic [2:0] unit = '0;
	logic [UNIT_N-1:0] periphSel, gates;
	int errors = 0, n_compared = 0;
	always #5 ref_clk = ~ref_clk;
	sleep_clock_gating_ctrl dut_u (.ref_clk, .rst_n, .regAddr, .regWdata, .regWrite, .regRead,
		.regRdata, .periphSel, .periphValid, .busFault, .irq,
		.async_serial_zero_gate(gates[0]), .async_serial_one_gate(gates[1]),
		.sync_serial_zero_gate(gates[2]), .two_wire_zero_gate(gates[3]),
		.general_counter_zero_gate(gates[4]), .general_counter_one_gate(gates[5]),
		.general_counter_two_gate(gates[6]), .comparator_zero_gate(gates[7]));
	periph_model pm_u (.unit, .go, .periphSel, .periphValid);
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge ref_clk);
		regWrite <= 1'b0;
	endtask : wr
	// Read data stand only in the cycle after the strobe
	task rd(input logic [ADDR_W-1:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge ref_clk);
		regRead <= 1'b0;
		#1 chk(regRdata, e);
	endtask : rd
	// Two edges give the registered gates time to follow a write
	task cg(input logic [8:0] e);
		repeat (2) @(posedge ref_clk);
		#1 chk(32'({irq, gates}), 32'(e));
	endtask : cg
	task acc(input logic [2:0] u, input logic [1:0] e);
		@(posedge ref_clk);
		unit <= u;
		go <= 1'b1;
		@(posedge ref_clk);
		go <= 1'b0;
		#1 chk(32'({busFault, irq}), 32'(e));
	endtask : acc
	task print_verdict;
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	// Watchdog: the sequence needs well under 1000 cycles
	initial begin
		#20000;
		errors++;
		print_verdict();
	end
	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1'b1;
		rd(SLEEP_GATE_OFS, 32'h0);
		rd(12'h300, 32'h0);
		acc(3'd0, 2'b10);
		wr(IRQ_CLEAR_OFS, 32'h1);
		wr(SLEEP_GATE_OFS, 32'hFFFF_FFFF);
		rd(SLEEP_GATE_OFS, 32'h0107_1013);
		wr(RUN_CFG_OFS, 32'h0800_0000);
		wr(POWER_MODE_OFS, 32'h1);
		// Walk one enable bit across every unit
		for (int i = 0; i < UNIT_N; i++) begin
			wr(SLEEP_GATE_OFS, 32'h1 << UNIT_BIT[i]);
			cg(9'h1 << i);
		end
		wr(RUN_GATE_OFS, 32'h1);
		wr(POWER_MODE_OFS, 32'h0);
		cg(9'h001);
		wr(DEEP_GATE_OFS, 32'h10);
		wr(POWER_MODE_OFS, 32'h2);
		cg(9'h004);
		wr(RUN_CFG_OFS, 32'h0);
		wr(POWER_MODE_OFS, 32'h1);
		cg(9'h001);
		wr(IRQ_ENABLE_OFS, 32'h1);
		acc(3'd1, 2'b11);
		acc(3'd0, 2'b01);
		rd(IRQ_STATUS_OFS, 32'h1);
		wr(IRQ_CLEAR_OFS, 32'h1);
		cg(9'h001);
		wr(IRQ_ENABLE_OFS, 32'h0);
		acc(3'd7, 2'b10);
		rd(IRQ_STATUS_OFS, 32'h1);
		print_verdict();
	end
endmodule : tb
